// File: common/spl_pkg.sv
package spl_pkg;

  // ----------------------------------------
  // Address and data layout
  // ----------------------------------------
  localparam int SPL_WIDTH = 16;
  localparam logic [15:0] SPL_FLOOR_ADDR = 16'h0800;
  localparam logic [15:0] SPL_WORD_STEP = 16'h0002;
  localparam logic [15:0] SPL_SP_RESET = 16'h0800;
  localparam logic [7:0] SPL_ZERO_BYTE = 8'h00;
  localparam int SPL_PC_HI_BITS = 7;
  localparam int SPL_ALIGN_BIT = 0;

  // ----------------------------------------
  // Request kinds
  // ----------------------------------------
  typedef enum logic [2:0] {
    SPL_OP_PUSH,
    SPL_OP_PUSH_CALL_HI,
    SPL_OP_PUSH_EXC_HI,
    SPL_OP_POP,
    SPL_OP_EA
  } spl_kind_t;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    spl_kind_t kind;
    logic [15:0] data;
    logic [15:0] ea;
    logic [7:0] status_low_byte;
  } spl_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } spl_wr_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } spl_mem_t;

endpackage

// File: hdl/spl_addr_check.sv
`timescale 1ns/1ps
module spl_addr_check (
  input wire logic [15:0] addr_in,  // Address formed through the stack pointer
  input wire logic [15:0] limit_in, // Stack limit, bit 0 already clear
  output logic over_out,            // Address beyond the limit
  output logic under_out            // Address below the floor
);

  // ----------------------------------------
  // Limit and floor compare
  // ----------------------------------------
  always_comb begin
    over_out = (addr_in > limit_in);
    under_out = (addr_in < spl_pkg::SPL_FLOOR_ADDR);
  end

endmodule

// File: hdl/spl_stack_check.sv
`timescale 1ns/1ps
// Behaviour
// - Pointer holds first free word, grows upward
// - Pop pre-decrements, push post-increments
// - Call pushes PC high part zero-extended
// - Exception push places status low byte high
// - Limit register has no reset value
// - Limit bit 0 reads and acts zero
// - Every pointer-based address checked against limit
// - Push at limit passes, next push traps
// - Address below floor raises underflow trap
module spl_stack_check (
  input wire logic clk_sys_in,                 // Core clock, 100 MHz
  input wire logic reset_in,                   // Synchronous reset, active high
  input wire spl_pkg::spl_req_t req_in,        // Stack request from address generation
  input wire spl_pkg::spl_wr_t sp_wr_in,       // Direct write of the stack pointer
  input wire spl_pkg::spl_wr_t limit_wr_in,    // Write of the stack limit
  output spl_pkg::spl_mem_t mem_out,           // Data memory access for push or pop
  output logic [15:0] sp_out,                  // Current stack pointer
  output logic stack_err_out,                  // Stack error trap request
  output logic overflow_out,                   // Trap cause: beyond limit
  output logic underflow_out                   // Trap cause: below floor
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] spl_step(input logic [15:0] sp, input logic up);
    spl_step = up ? 16'(sp + spl_pkg::SPL_WORD_STEP) : 16'(sp - spl_pkg::SPL_WORD_STEP);
  endfunction

  function automatic logic [15:0] spl_align(input logic [15:0] v);
    spl_align = {v[15:1], 1'b0};
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [15:0] sp_reg;
  logic [15:0] limit_reg;
  spl_pkg::spl_mem_t mem_reg;
  logic err_reg;
  logic over_reg;
  logic under_reg;

  logic is_push;
  logic is_pop;
  logic [15:0] chk_addr;
  logic [15:0] push_data;
  logic over_c;
  logic under_c;
  logic bad_c;

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  always_comb begin
    is_push = req_in.valid && (req_in.kind == spl_pkg::SPL_OP_PUSH ||
              req_in.kind == spl_pkg::SPL_OP_PUSH_CALL_HI || req_in.kind == spl_pkg::SPL_OP_PUSH_EXC_HI);
    is_pop = req_in.valid && (req_in.kind == spl_pkg::SPL_OP_POP);
    case (req_in.kind)
      spl_pkg::SPL_OP_POP: chk_addr = spl_step(sp_reg, 1'b0);
      spl_pkg::SPL_OP_EA: chk_addr = req_in.ea;
      default: chk_addr = sp_reg;
    endcase
  end

  always_comb begin
    case (req_in.kind)
      spl_pkg::SPL_OP_PUSH_CALL_HI:
        push_data = {spl_pkg::SPL_ZERO_BYTE, 1'b0, req_in.data[spl_pkg::SPL_PC_HI_BITS-1:0]};
      spl_pkg::SPL_OP_PUSH_EXC_HI:
        push_data = {req_in.status_low_byte, 1'b0, req_in.data[spl_pkg::SPL_PC_HI_BITS-1:0]};
      default: push_data = req_in.data;
    endcase
  end

  // ----------------------------------------
  // Limit and floor check
  // ----------------------------------------
  spl_addr_check u_check (
    .addr_in(chk_addr),
    .limit_in(limit_reg),
    .over_out(over_c),
    .under_out(under_c)
  );

  // Push at sp == limit is not over; the following one is
  assign bad_c = req_in.valid && (over_c || under_c);

  // ----------------------------------------
  // Stack limit, no reset
  // ----------------------------------------
  // Takes effect the next cycle; a checked access in the same cycle sees the old value
  always_ff @(posedge clk_sys_in) begin
    if (limit_wr_in.valid) begin
      limit_reg <= spl_align(limit_wr_in.data);
    end
  end

  // ----------------------------------------
  // Stack pointer
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      sp_reg <= spl_pkg::SPL_SP_RESET;
    end else if (sp_wr_in.valid) begin
      sp_reg <= spl_align(sp_wr_in.data);
    end else if (is_push && !bad_c) begin
      sp_reg <= spl_step(sp_reg, 1'b1);
    end else if (is_pop && !bad_c) begin
      sp_reg <= spl_step(sp_reg, 1'b0);
    end
  end

  // ----------------------------------------
  // Memory access
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      mem_reg <= '0;
    end else begin
      mem_reg.wr <= is_push && !bad_c;
      mem_reg.rd <= is_pop && !bad_c;
      mem_reg.addr <= chk_addr;
      mem_reg.wdata <= push_data;
    end
  end

  // ----------------------------------------
  // Trap request
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      err_reg <= 1'b0;
      over_reg <= 1'b0;
      under_reg <= 1'b0;
    end else begin
      err_reg <= bad_c;
      over_reg <= req_in.valid && over_c;
      under_reg <= req_in.valid && under_c;
    end
  end

  assign mem_out = mem_reg;
  assign sp_out = sp_reg;
  assign stack_err_out = err_reg;
  assign overflow_out = over_reg;
  assign underflow_out = under_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  logic push_ok;
  logic pop_ok;
  assign push_ok = is_push && !bad_c && !sp_wr_in.valid;
  assign pop_ok = is_pop && !bad_c && !sp_wr_in.valid;

  property p_push_inc;
    push_ok |=> sp_out == 16'($past(sp_reg) + spl_pkg::SPL_WORD_STEP) && mem_out.wr && mem_out.addr == $past(sp_reg);
  endproperty
  a_push_inc: assert property (p_push_inc) else $error("push did not write then increment");

  property p_pop_dec;
    pop_ok |=> mem_out.rd && mem_out.addr == sp_out && sp_out == 16'($past(sp_reg) - spl_pkg::SPL_WORD_STEP);
  endproperty
  a_pop_dec: assert property (p_pop_dec) else $error("pop did not decrement before read");

  property p_push_pop_free;
    push_ok ##1 pop_ok |=> mem_out.addr == $past(mem_out.addr) && mem_out.rd;
  endproperty
  a_push_pop_free: assert property (p_push_pop_free) else $error("pop missed last pushed word");

  property p_call_msb;
    req_in.valid && req_in.kind == spl_pkg::SPL_OP_PUSH_CALL_HI && !bad_c |=> mem_out.wr && mem_out.wdata[15:7] == '0;
  endproperty
  a_call_msb: assert property (p_call_msb) else $error("call push high part not zero-extended");

  property p_exc_srl;
    req_in.valid && req_in.kind == spl_pkg::SPL_OP_PUSH_EXC_HI && !bad_c
      |=> mem_out.wdata[15:8] == $past(req_in.status_low_byte) && !mem_out.wdata[7];
  endproperty
  a_exc_srl: assert property (p_exc_srl) else $error("exception push lacks status byte");

  property p_limit_lsb;
    limit_wr_in.valid |=> limit_reg[spl_pkg::SPL_ALIGN_BIT] == 1'b0;
  endproperty
  a_limit_lsb: assert property (p_limit_lsb) else $error("limit bit 0 not clear");

  property p_equal_ok;
    is_push && sp_reg == limit_reg && sp_reg >= spl_pkg::SPL_FLOOR_ADDR && !sp_wr_in.valid
      ##1 is_push && !sp_wr_in.valid |-> !stack_err_out ##1 stack_err_out && overflow_out;
  endproperty
  a_equal_ok: assert property (p_equal_ok) else $error("push at limit handled wrongly");

  property p_ea_over;
    req_in.valid && req_in.kind == spl_pkg::SPL_OP_EA && req_in.ea > limit_reg |=> overflow_out && stack_err_out;
  endproperty
  a_ea_over: assert property (p_ea_over) else $error("pointer address beyond limit not trapped");

  property p_under;
    is_pop && spl_step(sp_reg, 1'b0) < spl_pkg::SPL_FLOOR_ADDR |=> underflow_out && stack_err_out && !mem_out.rd;
  endproperty
  a_under: assert property (p_under) else $error("underflow not trapped");

  property p_err_pulse;
    stack_err_out |-> $past(req_in.valid) && ($past(over_c) || $past(under_c));
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("trap without a failed check");

  c_push_pop: cover property (push_ok ##1 pop_ok);
  c_over: cover property (is_push ##1 overflow_out);
  c_under: cover property (is_pop ##1 underflow_out);
  c_exc: cover property (req_in.valid && req_in.kind == spl_pkg::SPL_OP_PUSH_EXC_HI ##1 mem_out.wr);

endmodule

// File: sim/spl_mem_model.sv
`timescale 1ns/1ps
module spl_mem_model (
  input wire logic clk_sys_in,               // Core clock
  input wire spl_pkg::spl_mem_t mem_in,      // Access from the stack block
  output logic [15:0] rdata_out              // Read data, one cycle after rd
);
  logic [15:0] mem [256];

  // ----------------------------------------
  // Word store, read data churns when idle
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (mem_in.wr) begin
      mem[mem_in.addr[8:1]] <= mem_in.wdata;
    end
    if (mem_in.rd) begin
      rdata_out <= mem[mem_in.addr[8:1]];
    end else begin
      rdata_out <= ~rdata_out;
    end
  end
endmodule

// File: sim/tb_spl_stack_check.sv
`timescale 1ns/1ps
module tb_spl_stack_check;
  logic clk_sys_in;
  logic reset_in;
  spl_pkg::spl_req_t req_in;
  spl_pkg::spl_wr_t sp_wr_in;
  spl_pkg::spl_wr_t limit_wr_in;
  spl_pkg::spl_mem_t mem_out;
  logic [15:0] sp_out;
  logic stack_err_out;
  logic overflow_out;
  logic underflow_out;
  logic [15:0] rdata;
  int miscompares = 0;
  int cmp_count = 0;

  spl_stack_check i_spl_stack_check (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .req_in(req_in),
    .sp_wr_in(sp_wr_in), .limit_wr_in(limit_wr_in), .mem_out(mem_out), .sp_out(sp_out),
    .stack_err_out(stack_err_out), .overflow_out(overflow_out), .underflow_out(underflow_out));
  spl_mem_model i_spl_mem_model (.clk_sys_in(clk_sys_in), .mem_in(mem_out), .rdata_out(rdata));

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic op(input spl_pkg::spl_kind_t k, input logic [15:0] d, input logic [15:0] ea,
                    input logic [7:0] slb, input logic [15:0] e_addr, input logic [15:0] e_dat,
                    input logic [15:0] e_sp, input logic [1:0] e_acc, input logic [1:0] e_err);
    @(posedge clk_sys_in);
    req_in <= '{1'b1, k, d, ea, slb};
    @(posedge clk_sys_in);
    req_in.valid <= 1'b0;
    #1;
    chk(16'({mem_out.rd, mem_out.wr}), 16'(e_acc), "rd wr");
    if (e_acc != 2'b00) chk(mem_out.addr, e_addr, "address");
    if (e_acc == 2'b01) chk(mem_out.wdata, e_dat, "write data");
    chk(sp_out, e_sp, "pointer");
    chk(16'({overflow_out, underflow_out}), 16'(e_err), "cause");
    chk(16'(stack_err_out), 16'(e_err != 2'b00), "trap");
    @(posedge clk_sys_in);
    #1;
    chk(16'(stack_err_out), 16'h0000, "trap pulse end");
    if (e_acc == 2'b10) chk(rdata, e_dat, "pop data");
  endtask

  // Judges the outputs launched by the edge just passed
  task automatic look(input logic [1:0] e_acc, input logic [15:0] e_addr, input logic [15:0] e_sp,
                      input logic e_err);
    #1;
    chk(16'({mem_out.rd, mem_out.wr}), 16'(e_acc), "rd wr");
    if (e_acc != 2'b00) chk(mem_out.addr, e_addr, "address");
    chk(sp_out, e_sp, "pointer");
    chk(16'({stack_err_out, overflow_out, underflow_out}), 16'({e_err, e_err, 1'b0}), "trap");
  endtask

  task automatic set_reg(input logic lim, input logic [15:0] v);
    @(posedge clk_sys_in);
    if (lim) limit_wr_in <= '{1'b1, v};
    else sp_wr_in <= '{1'b1, v};
    @(posedge clk_sys_in);
    limit_wr_in.valid <= 1'b0;
    sp_wr_in.valid <= 1'b0;
    @(posedge clk_sys_in); // Idle cycle before any pointer access
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_push_pop();
    #1;
    chk(sp_out, 16'h0800, "reset pointer");
    set_reg(1'b1, 16'h0ffe);
    op(spl_pkg::SPL_OP_PUSH, 16'h1234, 16'h0, 8'h0, 16'h0800, 16'h1234, 16'h0802, 2'b01, 2'b00);
    op(spl_pkg::SPL_OP_PUSH, 16'h5678, 16'h0, 8'h0, 16'h0802, 16'h5678, 16'h0804, 2'b01, 2'b00);
    op(spl_pkg::SPL_OP_POP, 16'h0, 16'h0, 8'h0, 16'h0802, 16'h5678, 16'h0802, 2'b10, 2'b00);
    op(spl_pkg::SPL_OP_POP, 16'h0, 16'h0, 8'h0, 16'h0800, 16'h1234, 16'h0800, 2'b10, 2'b00);
    $display("test push_pop done");
  endtask

  task automatic test_pc_push();
    op(spl_pkg::SPL_OP_PUSH_CALL_HI, 16'hffff, 16'h0, 8'ha5, 16'h0800, 16'h007f, 16'h0802, 2'b01, 2'b00);
    op(spl_pkg::SPL_OP_PUSH_EXC_HI, 16'hffff, 16'h0, 8'ha5, 16'h0802, 16'ha57f, 16'h0804, 2'b01, 2'b00);
    $display("test pc_push done");
  endtask

  task automatic test_limit();
    set_reg(1'b1, 16'h0805);
    set_reg(1'b0, 16'h0802);
    op(spl_pkg::SPL_OP_PUSH, 16'h0011, 16'h0, 8'h0, 16'h0802, 16'h0011, 16'h0804, 2'b01, 2'b00);
    op(spl_pkg::SPL_OP_PUSH, 16'h0022, 16'h0, 8'h0, 16'h0804, 16'h0022, 16'h0806, 2'b01, 2'b00);
    op(spl_pkg::SPL_OP_PUSH, 16'h0033, 16'h0, 8'h0, 16'h0806, 16'h0033, 16'h0806, 2'b00, 2'b10);
    op(spl_pkg::SPL_OP_EA, 16'h0, 16'h0805, 8'h0, 16'h0, 16'h0, 16'h0806, 2'b00, 2'b10);
    op(spl_pkg::SPL_OP_EA, 16'h0, 16'h0804, 8'h0, 16'h0, 16'h0, 16'h0806, 2'b00, 2'b00);
    $display("test limit done");
  endtask

  task automatic test_underflow();
    set_reg(1'b0, 16'h0800);
    op(spl_pkg::SPL_OP_POP, 16'h0, 16'h0, 8'h0, 16'h0, 16'h0, 16'h0800, 2'b00, 2'b01);
    op(spl_pkg::SPL_OP_EA, 16'h0, 16'h07ff, 8'h0, 16'h0, 16'h0, 16'h0800, 2'b00, 2'b01);
    $display("test underflow done");
  endtask

  // Requests on consecutive cycles: push, pop, push, push at limit, push beyond
  task automatic test_back_to_back();
    set_reg(1'b1, 16'h0802);
    set_reg(1'b0, 16'h0800);
    @(posedge clk_sys_in);
    req_in <= '{1'b1, spl_pkg::SPL_OP_PUSH, 16'h00aa, 16'h0, 8'h0};
    @(posedge clk_sys_in);
    req_in.kind <= spl_pkg::SPL_OP_POP;
    look(2'b01, 16'h0800, 16'h0802, 1'b0);
    chk(mem_out.wdata, 16'h00aa, "write data");
    @(posedge clk_sys_in);
    req_in <= '{1'b1, spl_pkg::SPL_OP_PUSH, 16'h00bb, 16'h0, 8'h0};
    look(2'b10, 16'h0800, 16'h0800, 1'b0);
    @(posedge clk_sys_in);
    req_in.data <= 16'h00cc;
    look(2'b01, 16'h0800, 16'h0802, 1'b0);
    chk(rdata, 16'h00aa, "pop data");
    @(posedge clk_sys_in);
    look(2'b01, 16'h0802, 16'h0804, 1'b0);
    @(posedge clk_sys_in);
    req_in.valid <= 1'b0;
    look(2'b00, 16'h0000, 16'h0804, 1'b1);
    @(posedge clk_sys_in);
    look(2'b00, 16'h0000, 16'h0804, 1'b0);
    $display("test back_to_back done");
  endtask

  initial begin
    reset_in = 1'b1;
    req_in = '0;
    sp_wr_in = '0;
    limit_wr_in = '0;
    repeat (4) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    test_push_pop();
    test_pc_push();
    test_limit();
    test_underflow();
    test_back_to_back();
    finish_test();
  end
endmodule
